// ### rtl/watchdog_unit_consts.svh
// Offsets, field positions, reset values and keys of the watchdog unit.
// Assumes inclusion by bare name from rtl/.
`ifndef WATCHDOG_UNIT_CONSTS_SVH
`define WATCHDOG_UNIT_CONSTS_SVH

`define WD_COUNT_ADDR        32'hFFFFFF84
`define WD_CTRL_ADDR         32'hFFFFFF86
`define WD_COUNT_KEY         8'h5A
`define WD_CTRL_KEY          8'hA5
`define WD_COUNT_RESET       8'h00
`define WD_CTRL_RESET        8'h00
`define WD_BIT_RUN           7
`define WD_BIT_KIND          6
`define WD_BIT_RST_KIND      5
`define WD_BIT_WATCHDOG_OVERFLOW_FLAG          4
`define WD_BIT_INTERVAL_OVERFLOW_FLAG          3
`define WD_CLK_SEL_MSB       2
`define WD_PRESCALE_WIDTH    12

`endif

// ### rtl/watchdog_unit_pkg.sv
// Types shared by the watchdog unit.
// Assumes nothing beyond a SystemVerilog compiler.
package watchdog_unit_pkg;
  typedef enum logic [1:0] {
    ACC_BYTE,
    ACC_WORD,
    ACC_LONG
  } access_size_e;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_RELEASE
  } settle_state_e;
endpackage

// ### rtl/watchdog_unit.sv
// Watchdog / interval timer with PLL settling count.
// Assumes one 10 MHz clock; i_periph_tick marks each peripheral clock edge.
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_unit_consts.svh"

// How it works
// - PLL ratio change runs a settling count
// - Ratio write halts processor, counter starts
// - Overflow resumes clocks, counter stops same cycle if bit 7 clear
// - Divider-only change runs no settling count
// - Divider-only change applies immediately
// - 8-bit counter, cleared by power-on reset
// - Overflow: reset in watchdog, interrupt interval
// - Counter written by word with key 5A
// - Control written by word with key A5
// - Both registers read by byte
// - Control cleared only by power-on reset
// - Control kept after standby settling overflow
// - Run bit 7 stops and holds count
// - Bit 6 selects interval or watchdog
// - Bit 5 selects power-on or manual reset
// - Bit 4 set on watchdog-mode overflow only
// - Bit 3 set on interval-mode overflow only
// - Bits 2..0 select prescaler divide ratio
// - Settling overflow leaves watchdog flag clear
// - Counter rests at 00 or 01 after settling
// - Interval overflow flags, interrupts, keeps counting
module watchdog_unit #(
  parameter int PRESCALE_WIDTH = `WD_PRESCALE_WIDTH
) (
  // Clock and power-on reset
  input  wire logic                         i_clock,
  input  wire logic                         i_srst,
  // Peripheral clock tick (one cycle per peripheral clock edge)
  input  wire logic                         i_periph_tick,
  // Processor register port
  input  wire logic                         i_reg_write,
  input  wire logic                         i_reg_read,
  input  wire logic [31:0]                  i_reg_addr,
  input  wire watchdog_unit_pkg::access_size_e i_reg_size,
  input  wire logic [15:0]                  i_reg_wdata,
  output logic      [7:0]                   o_reg_rdata,
  output logic                              o_reg_rvalid,
  // Frequency control register write from the clock generator
  input  wire logic                         i_freq_write,
  input  wire logic                         i_pll_mult_changed,
  input  wire logic                         i_standby_settle_start,
  // Clock control toward the clock generator and processor
  output logic                              o_clock_hold,
  output logic                              o_clock_resume,
  // Reset and interrupt outputs
  output logic                              o_power_on_reset_req,
  output logic                              o_manual_reset_req,
  output logic                              o_interval_irq
);
  import watchdog_unit_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]                watchdog_count;
  logic [7:0]                watchdog_control_status;
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic [PRESCALE_WIDTH-1:0] next_prescale;
  logic [PRESCALE_WIDTH-1:0] tick_mask;
  settle_state_e             settle_state;
  logic                      settle_standby;
  logic                      count_tick;
  logic                      overflow;
  logic                      counting;
  logic                      count_write;
  logic                      ctrl_write;
  logic                      timer_run;
  logic                      timer_kind_sel;
  logic                      reset_kind_sel;
  logic [2:0]                count_clock_sel;
  logic                      settling;
  logic                      settle_start;

  assign timer_run       = watchdog_control_status[`WD_BIT_RUN];
  assign timer_kind_sel  = watchdog_control_status[`WD_BIT_KIND];
  assign reset_kind_sel  = watchdog_control_status[`WD_BIT_RST_KIND];
  assign count_clock_sel = watchdog_control_status[`WD_CLK_SEL_MSB:0];
  assign settling        = (settle_state == ST_SETTLE);

  // Settling count triggered by ratio write or standby settle start
  assign settle_start = (i_freq_write && i_pll_mult_changed)
                        || i_standby_settle_start;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Keyed word writes to counter and control
  assign count_write = i_reg_write && (i_reg_size == ACC_WORD)
                       && (i_reg_addr == `WD_COUNT_ADDR)
                       && (i_reg_wdata[15:8] == `WD_COUNT_KEY);
  assign ctrl_write  = i_reg_write && (i_reg_size == ACC_WORD)
                       && (i_reg_addr == `WD_CTRL_ADDR)
                       && (i_reg_wdata[15:8] == `WD_CTRL_KEY);

  // ---------------------------------------------------------------
  // Prescaler and count clock
  // ---------------------------------------------------------------
  // Divide ratio mask per select code
  always_comb begin
    case (count_clock_sel)
      3'h0:    tick_mask = PRESCALE_WIDTH'(0);
      3'h1:    tick_mask = PRESCALE_WIDTH'(3);
      3'h2:    tick_mask = PRESCALE_WIDTH'(15);
      3'h3:    tick_mask = PRESCALE_WIDTH'(31);
      3'h4:    tick_mask = PRESCALE_WIDTH'(63);
      3'h5:    tick_mask = PRESCALE_WIDTH'(255);
      3'h6:    tick_mask = PRESCALE_WIDTH'(1023);
      default: tick_mask = PRESCALE_WIDTH'(4095);
    endcase
  end

  // Count only while running or settling
  assign counting   = timer_run || settling;
  assign count_tick = counting && i_periph_tick
                      && ((prescale & tick_mask) == tick_mask);
  assign overflow   = count_tick && (watchdog_count == 8'hFF);
  assign next_prescale = prescale + PRESCALE_WIDTH'(1);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      prescale <= '0;
    end else if (!counting) begin
      prescale <= '0;
    end else if (i_periph_tick) begin
      prescale <= next_prescale;
    end
  end

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  // Counter cleared by power-on reset
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      watchdog_count <= `WD_COUNT_RESET;
    end else if (count_write) begin
      watchdog_count <= i_reg_wdata[7:0];
    end else if (count_tick) begin
      watchdog_count <= watchdog_count + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Settling sequencer
  // ---------------------------------------------------------------
  // Hold clocks while settling
  // Stopping after wrap leaves count at 00
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      settle_state   <= ST_IDLE;
      settle_standby <= 1'b0;
    end else begin
      case (settle_state)
        ST_IDLE: begin
          if (settle_start) begin
            settle_state   <= ST_SETTLE;
            settle_standby <= i_standby_settle_start;
          end
        end
        ST_SETTLE: begin
          if (overflow) begin
            settle_state <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          settle_state <= ST_IDLE;
        end
        default: begin
          settle_state <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_clock_hold   = settling;
  assign o_clock_resume = (settle_state == ST_RELEASE);

  // ---------------------------------------------------------------
  // Control / status
  // ---------------------------------------------------------------
  // Only power-on reset clears control
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      watchdog_control_status <= `WD_CTRL_RESET;
    end else begin
      if (ctrl_write) begin
        watchdog_control_status <= i_reg_wdata[7:0];
      end
      if (overflow && !settling && timer_kind_sel) begin
        watchdog_control_status[`WD_BIT_WATCHDOG_OVERFLOW_FLAG] <= 1'b1;
      end
      if (overflow && !settling && !timer_kind_sel) begin
        watchdog_control_status[`WD_BIT_INTERVAL_OVERFLOW_FLAG] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Reset and interrupt requests
  // ---------------------------------------------------------------
  // Overflow action by mode
  // Reset kind chosen by bit 5
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_power_on_reset_req <= 1'b0;
      o_manual_reset_req   <= 1'b0;
      o_interval_irq       <= 1'b0;
    end else begin
      o_power_on_reset_req <= overflow && !settling && timer_kind_sel
                              && !reset_kind_sel;
      o_manual_reset_req   <= overflow && !settling && timer_kind_sel
                              && reset_kind_sel;
      o_interval_irq       <= overflow && !settling && !timer_kind_sel;
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  // Byte read returns register value
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_read;
      if (i_reg_read && i_reg_addr == `WD_COUNT_ADDR) begin
        o_reg_rdata <= watchdog_count;
      end else if (i_reg_read && i_reg_addr == `WD_CTRL_ADDR) begin
        o_reg_rdata <= watchdog_control_status;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_count_reset: assert property (@(posedge i_clock)
    i_srst |=> watchdog_count == 8'h00)
    else $error("counter not cleared by reset");
  a_count_key: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (i_reg_write && i_reg_addr == `WD_COUNT_ADDR && i_reg_size != ACC_WORD
     && !count_tick) |=> $stable(watchdog_count))
    else $error("non-word write changed counter");
  a_ctrl_key: assert property (
    @(posedge i_clock) disable iff (i_srst)
    ctrl_write |=> watchdog_control_status[7:5] == $past(i_reg_wdata[7:5]))
    else $error("keyed control write not stored");
  a_run_hold: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (!timer_run && !settling && !count_write) |=> $stable(watchdog_count))
    else $error("counter moved while stopped");
  a_watchdog_overflow_flag_set: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (overflow && !settling && timer_kind_sel) |=>
      watchdog_control_status[`WD_BIT_WATCHDOG_OVERFLOW_FLAG])
    else $error("watchdog flag not set");
  a_interval_overflow_flag_irq: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (overflow && !settling && !timer_kind_sel) |=>
      o_interval_irq && watchdog_control_status[`WD_BIT_INTERVAL_OVERFLOW_FLAG])
    else $error("interval overflow not signalled");
  a_settle_hold: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (settle_state == ST_IDLE && settle_start) |=> o_clock_hold)
    else $error("settling did not hold clocks");
  a_settle_end: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (settling && overflow) |=> o_clock_resume ##1 !o_clock_hold)
    else $error("settling overflow did not resume");
  a_settle_noflag: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (settling && overflow && !ctrl_write) |=>
      $stable(watchdog_control_status))
    else $error("settling overflow changed control");
  a_div_only: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (settle_state == ST_IDLE && i_freq_write && !i_pll_mult_changed
     && !i_standby_settle_start) |=> !o_clock_hold)
    else $error("divider change started settling");
  a_standby_keep: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (settling && settle_standby && overflow && !ctrl_write) |=>
      $stable(watchdog_control_status))
    else $error("standby settling changed control");
  a_count_wrap: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (overflow && !count_write) |=> watchdog_count == 8'h00)
    else $error("overflow did not wrap to zero");
  a_read_count: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (i_reg_read && i_reg_addr == `WD_COUNT_ADDR) |=>
      o_reg_rvalid && o_reg_rdata == $past(watchdog_count))
    else $error("counter read returned wrong value");
  a_settle_rest: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (o_clock_resume && !timer_run && !count_write && !$past(count_write))
      |=> watchdog_count <= 8'h01)
    else $error("counter did not rest after settling");
  a_reset_kind: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (overflow && !settling && timer_kind_sel) |=>
      (o_manual_reset_req == $past(reset_kind_sel))
      && (o_power_on_reset_req == !$past(reset_kind_sel)))
    else $error("wrong reset kind requested");
  a_wd_no_interval_overflow_flag: assert property (
    @(posedge i_clock) disable iff (i_srst)
    (overflow && !settling && timer_kind_sel && !ctrl_write) |=>
      $stable(watchdog_control_status[`WD_BIT_INTERVAL_OVERFLOW_FLAG]))
    else $error("watchdog overflow set interval flag");

  c_watchdog_reset: cover property (@(posedge i_clock)
    o_power_on_reset_req);
  c_manual_reset: cover property (@(posedge i_clock) o_manual_reset_req);
  c_interval_irq: cover property (@(posedge i_clock) o_interval_irq);
  c_settle_done: cover property (@(posedge i_clock) o_clock_resume);
  c_slow_count: cover property (@(posedge i_clock)
    count_tick && count_clock_sel == 3'h7);
endmodule

`default_nettype wire

// ### verification/periph_clock_model.sv
// Far-side model: clock generator giving the peripheral clock tick.
// Assumes the bench enables it; ticks land just after a falling edge.
`timescale 1ns/1ns
`default_nettype none

module periph_clock_model (
  // Clock and control
  input  wire logic i_clock,
  input  wire logic i_tick_en,
  // Peripheral clock tick
  output logic      o_periph_tick
);
  // ----------------------------------------
  // Tick source
  // ----------------------------------------
  // Clocks keep running; one tick a cycle
  always_ff @(negedge i_clock) begin
    o_periph_tick <= i_tick_en;
  end
endmodule

`default_nettype wire

// ### verification/tb_watchdog_with_pll_settling_count.sv
// Self-checking bench for the watchdog unit.
// Assumes the design package and the constants header are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "watchdog_unit_consts.svh"

module tb_watchdog_with_pll_settling_count;
  import watchdog_unit_pkg::*;
  logic         clock, srst, tick_en, wr_en, rd_en, freq_wr, mult, stby;
  logic [31:0]  addr;
  access_size_e size;
  logic [15:0]  wdata;
  logic [7:0]   rdata, got;
  logic         rvalid, tick, hold, resume, por, man, irq;
  int           fail_count, n_checks, n_por, n_man, n_irq, n;
  int           divs [8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};

  periph_clock_model partner (.i_clock(clock), .i_tick_en(tick_en),
    .o_periph_tick(tick));
  watchdog_unit uut (.i_clock(clock), .i_srst(srst), .i_periph_tick(tick),
    .i_reg_write(wr_en), .i_reg_read(rd_en), .i_reg_addr(addr),
    .i_reg_size(size), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_freq_write(freq_wr),
    .i_pll_mult_changed(mult), .i_standby_settle_start(stby),
    .o_clock_hold(hold), .o_clock_resume(resume),
    .o_power_on_reset_req(por), .o_manual_reset_req(man),
    .o_interval_irq(irq));

  // ----------------------------------------
  // Clock and pulse tallies
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(negedge clock) begin
    n_por += int'(por === 1'b1);
    n_man += int'(man === 1'b1);
    n_irq += int'(irq === 1'b1);
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input access_size_e s,
                    input logic [15:0] d);
    @(negedge clock);
    wr_en = 1'b1;
    addr  = a;
    size  = s;
    wdata = d;
    @(negedge clock);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [7:0] g);
    @(negedge clock);
    rd_en = 1'b1;
    addr  = a;
    size  = ACC_BYTE;
    @(negedge clock);
    rd_en = 1'b0;
    g = rdata;
    chk("read valid", 8'h01, {7'h00, rvalid});
  endtask
  task automatic pulse(input logic m, input logic s);
    @(negedge clock);
    freq_wr = ~s;
    mult    = m;
    stby    = s;
    @(negedge clock);
    freq_wr = 1'b0;
    stby    = 1'b0;
  endtask
  // Waits on irq (0), power-on (1), manual (2) or resume (3)
  task automatic wait_on(input int which, input int lim, output int c);
    bit hit;
    hit = 0;
    for (c = 0; c < lim && !hit; c++) begin
      @(negedge clock);
      case (which)
        0: hit = (irq === 1'b1);
        1: hit = (por === 1'b1);
        2: hit = (man === 1'b1);
        default: hit = (resume === 1'b1);
      endcase
    end
    if (!hit) begin
      fail_count++;
      $display("Error wait %0d expected 1 seen 0", which);
      give_verdict();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(`WD_COUNT_ADDR, got);
    chk("count reset", 8'h00, got);
    rd(`WD_CTRL_ADDR, got);
    chk("ctrl reset", 8'h00, got);
    chk("hold idle", 8'h00, {7'h00, hold});
  endtask
  task automatic t_keys;
    logic [31:0] a;
    logic [7:0]  k;
    for (int i = 0; i < 2; i++) begin
      a = i ? `WD_CTRL_ADDR : `WD_COUNT_ADDR;
      k = i ? `WD_CTRL_KEY : `WD_COUNT_KEY;
      wr(a, ACC_BYTE, {k, 8'h07});
      wr(a, ACC_LONG, {k, 8'h07});
      wr(a, ACC_WORD, {~k, 8'h07});
      rd(a, got);
      chk("refused write", 8'h00, got);
      wr(a, ACC_WORD, {k, 8'h07});
      rd(a, got);
      chk("keyed write", 8'h07, got);
    end
  endtask
  task automatic t_run_hold;
    tick_en = 1'b1;
    wr(`WD_COUNT_ADDR, ACC_WORD, 16'h5A40);
    wr(`WD_CTRL_ADDR, ACC_WORD, 16'hA500);
    repeat (20) @(negedge clock);
    rd(`WD_COUNT_ADDR, got);
    chk("count held", 8'h40, got);
    wr(`WD_CTRL_ADDR, ACC_WORD, 16'hA580);
    repeat (10) @(negedge clock);
    wr(`WD_CTRL_ADDR, ACC_WORD, 16'hA500);
    rd(`WD_COUNT_ADDR, got);
    chk("count runs", 8'h01, 8'(got > 8'h40 && got < 8'h50));
  endtask
  task automatic t_interval;
    wr(`WD_COUNT_ADDR, ACC_WORD, 16'h5AFD);
    wr(`WD_CTRL_ADDR, ACC_WORD, 16'hA5A0);
    wait_on(0, 20, n);
    rd(`WD_CTRL_ADDR, got);
    chk("interval flag", 8'hA8, got);
    wait_on(0, 270, n);
    wr(`WD_CTRL_ADDR, ACC_WORD, 16'hA500);
    chk("interval irqs", 8'h02, 8'(n_irq));
    chk("no reset", 8'h00, 8'(n_por + n_man));
  endtask
  task automatic t_watchdog;
    for (int rk = 0; rk < 2; rk++) begin
      wr(`WD_COUNT_ADDR, ACC_WORD, 16'h5AFE);
      wr(`WD_CTRL_ADDR, ACC_WORD, {8'hA5, 8'hC0 | 8'(rk << 5)});
      wait_on(rk ? 2 : 1, 20, n);
      rd(`WD_CTRL_ADDR, got);
      chk("wd flag", 8'hD0 | 8'(rk << 5), got);
      wr(`WD_CTRL_ADDR, ACC_WORD, 16'hA500);
    end
    chk("por count", 8'h01, 8'(n_por));
    chk("manual count", 8'h01, 8'(n_man));
    chk("no irq", 8'h02, 8'(n_irq));
  endtask
  task automatic t_prescale;
    for (int c = 0; c < 8; c++) begin
      wr(`WD_COUNT_ADDR, ACC_WORD, 16'h5AFF);
      wr(`WD_CTRL_ADDR, ACC_WORD, {8'hA5, 8'h80 | 8'(c)});
      wait_on(0, 4200, n);
      wr(`WD_CTRL_ADDR, ACC_WORD, 16'hA500);
      chk("divide delay", 8'h01, 8'(n == divs[c]));
    end
  endtask
  task automatic t_settle;
    n_irq = 0;
    wr(`WD_CTRL_ADDR, ACC_WORD, 16'hA500);
    wr(`WD_COUNT_ADDR, ACC_WORD, 16'h5AFC);
    pulse(1'b0, 1'b0);
    repeat (5) begin
      @(negedge clock);
      chk("divider only hold", 8'h00, {7'h00, hold});
    end
    rd(`WD_COUNT_ADDR, got);
    chk("divider only count", 8'hFC, got);
    pulse(1'b1, 1'b0);
    chk("settle hold", 8'h01, {7'h00, hold});
    wait_on(3, 20, n);
    chk("settle length", 8'h01, 8'(n >= 2 && n <= 7));
    chk("hold released", 8'h00, {7'h00, hold});
    repeat (5) @(negedge clock);
    rd(`WD_COUNT_ADDR, got);
    chk("rest value", 8'h01, 8'(got <= 8'h01));
    rd(`WD_CTRL_ADDR, got);
    chk("no settle flag", 8'h00, got);
    chk("settle quiet", 8'h00, 8'(n_irq + n_por + n_man - 2));
  endtask
  task automatic t_standby;
    wr(`WD_CTRL_ADDR, ACC_WORD, 16'hA542);
    wr(`WD_COUNT_ADDR, ACC_WORD, 16'h5AFE);
    pulse(1'b0, 1'b1);
    wait_on(3, 100, n);
    rd(`WD_CTRL_ADDR, got);
    chk("standby ctrl kept", 8'h42, got);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {srst, tick_en, wr_en, rd_en, freq_wr, mult, stby} = 7'h40;
    addr       = 32'h0000_0000;
    size       = ACC_WORD;
    wdata      = 16'h0000;
    fail_count = 0;
    n_checks   = 0;
    n_por      = 0;
    n_man      = 0;
    n_irq      = 0;
    repeat (8) @(negedge clock);
    srst = 1'b0;
    t_reset();
    t_keys();
    t_run_hold();
    t_interval();
    t_watchdog();
    t_prescale();
    t_settle();
    t_standby();
    give_verdict();
  end
endmodule

`default_nettype wire
